// *** gdps_consts.vh ***
// gdps_consts.vh: offsets, field layout, reset values and times of the
// protection and sense configuration bank.
// assumes: included by its bare name from each design file.
`ifndef GDPS_CONSTS_VH
`define GDPS_CONSTS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define GDPS_CLK_MHZ        100
`define GDPS_RETRY_LONG_US  8000
`define GDPS_RETRY_SHORT_US 50
`define GDPS_FILT_US_0      1
`define GDPS_FILT_US_1      2
`define GDPS_FILT_US_2      4
`define GDPS_FILT_US_3      8
`define GDPS_GAP_NS_0       50
`define GDPS_GAP_NS_1       100
`define GDPS_GAP_NS_2       200
`define GDPS_GAP_NS_3       400

// ----------------------------------------------------------------
// serial frame: rw, 4 address bits, 11 data bits
// ----------------------------------------------------------------
`define GDPS_FRAME_BITS 5'h10
`define GDPS_HDR_BITS   5'h05
`define GDPS_RW_BIT     15
`define GDPS_ADDR_HI    14
`define GDPS_ADDR_LO    11
`define GDPS_DW         11

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define GDPS_ADDR_OCP 4'h5
`define GDPS_ADDR_AMP 4'h6
`define GDPS_ADDR_DRV 4'h7
`define GDPS_RST_OCP  11'h169
`define GDPS_RST_AMP  11'h283
`define GDPS_RST_DRV  11'h000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GDPS_F_RETRY      10
`define GDPS_F_GAP        9:8
`define GDPS_F_MODE       7:6
`define GDPS_F_FILT       5:4
`define GDPS_F_DS_LVL     3:0
`define GDPS_F_SRC        10
`define GDPS_F_HALF       9
`define GDPS_F_LSREF      8
`define GDPS_F_GAIN       7:6
`define GDPS_F_SDIS       5
`define GDPS_F_CAL_A      4
`define GDPS_F_CAL_B      3
`define GDPS_F_CAL_C      2
`define GDPS_F_SLVL       1:0
`define GDPS_F_AUTOCAL    0

// ----------------------------------------------------------------
// overcurrent response codes
// ----------------------------------------------------------------
`define GDPS_MODE_LATCH  2'h0
`define GDPS_MODE_RETRY  2'h1
`define GDPS_MODE_REPORT 2'h2
`define GDPS_MODE_OFF    2'h3

`endif

// *** gdps_oc_guard.v ***
// gdps_oc_guard.v: filter and fault response for one overcurrent source.
// assumes: oc_in is already synchronised to clock; pulses are one cycle.
`timescale 1ns/100ps
`include "gdps_consts.vh"

module gdps_oc_guard #(
  parameter CW = 20
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          oc_in,
  input  wire          enable,
  input  wire [1:0]    mode,
  input  wire [9:0]    filt_cycles,
  input  wire [CW-1:0] retry_cycles,
  input  wire          cycle_clear,
  input  wire          pwm_edge,
  input  wire          fault_clear,
  output reg           report_r,
  output reg           shutdown_r
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_LATCH = 2'h1;
  localparam ST_RETRY = 2'h2;

  reg [1:0]    st_r;
  reg [9:0]    filt_r;
  reg [CW-1:0] tmr_r;
  wire         active;
  wire         hit;

  // ----------------------------------------------------------------
  // persistence filter
  // ----------------------------------------------------------------
  assign active = oc_in & enable;
  // hit stays high while the condition persists past the filter
  assign hit = active & (filt_r >= filt_cycles - 10'h001);

  always @(posedge clock)
  begin
    if (!rst_n)
      filt_r <= 10'h000;
    else if (!active)
      filt_r <= 10'h000;
    else if (!hit)
      filt_r <= filt_r + 10'h001;
  end

  // ----------------------------------------------------------------
  // response
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_r       <= ST_IDLE;
      tmr_r      <= {CW{1'b0}};
      report_r   <= 1'b0;
      shutdown_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          report_r   <= hit & (mode != `GDPS_MODE_OFF);
          shutdown_r <= 1'b0;
          if (hit && mode == `GDPS_MODE_LATCH)
          begin
            st_r       <= ST_LATCH;
            report_r   <= 1'b1;
            shutdown_r <= 1'b1;
          end
          else if (hit && mode == `GDPS_MODE_RETRY)
          begin
            st_r       <= ST_RETRY;
            tmr_r      <= retry_cycles;
            report_r   <= 1'b1;
            shutdown_r <= 1'b1;
          end
        end
        ST_LATCH:
        begin
          // a new hit in the clear cycle keeps the fault
          if (fault_clear && !hit)
          begin
            st_r       <= ST_IDLE;
            report_r   <= 1'b0;
            shutdown_r <= 1'b0;
          end
        end
        ST_RETRY:
        begin
          // early clear on a new pwm edge only in retry mode
          if (tmr_r == {CW{1'b0}} ||
              (cycle_clear && pwm_edge))
          begin
            st_r       <= ST_IDLE;
            report_r   <= 1'b0;
            shutdown_r <= 1'b0;
          end
          else
            tmr_r <= tmr_r - {{(CW-1){1'b0}}, 1'b1};
        end
        default:
        begin
          st_r       <= ST_IDLE;
          report_r   <= 1'b0;
          shutdown_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** gdps_cfg.v ***
// gdps_cfg.v: serial-accessed protection and current-sense configuration
// bank of a three-phase gate driver, with the overcurrent responses.
// assumes: serial pins and comparator inputs are asynchronous; pwm_edge,
// fault_clear and cycle_clear come from logic on clock.
//
// Behaviour
// - retry bit clear long wait, set short
// - gap code picks 50/100/200/400 ns dead time
// - response code 00 gives latched fault
// - response code 01 gives self-clearing retry fault
// - response code 10 reports only, no action
// - response code 11 neither reports nor acts
// - filter code needs 1/2/4/8 us persistence
// - source bit routes switch node, forces trip ref
// - halving bit selects half reference when set
// - trip ref bit picks positive or negative shunt
// - gain code gives 5/10/20/40 V/V
// - shunt trip disable suppresses shunt fault
// - calibration bits short own amplifier inputs
// - shunt level code gives 0.25 to 1 V
// - bit 0 selects automatic amplifier calibration
// - cycle clear acts only in retry mode
`timescale 1ns/100ps
`include "gdps_consts.vh"

module gdps_cfg #(
  parameter RETRY_LONG_CYC  = `GDPS_RETRY_LONG_US * `GDPS_CLK_MHZ,
  parameter RETRY_SHORT_CYC = `GDPS_RETRY_SHORT_US * `GDPS_CLK_MHZ
) (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       spi_cs_n,
  input  wire       spi_sclk,
  input  wire       spi_mosi,
  output reg        spi_miso_r,
  output reg        spi_miso_oe_r,
  input  wire       drain_source_overcurrent,
  input  wire       shunt_overcurrent,
  input  wire       pwm_edge,
  input  wire       fault_clear,
  input  wire       cycle_clear_sel,
  output reg  [5:0] dead_time_cycles_r,
  output reg  [3:0] drain_source_trip_sel_r,
  output reg        amp_input_source_sel_r,
  output reg        amp_ref_half_r,
  output reg        low_side_trip_ref_sel_r,
  output reg  [1:0] amp_gain_sel_r,
  output reg  [1:0] shunt_trip_level_sel_r,
  output reg        amp_a_offset_short_r,
  output reg        amp_b_offset_short_r,
  output reg        amp_c_offset_short_r,
  output reg        auto_cal_r,
  output wire       ds_fault_r,
  output wire       ds_shutdown_r,
  output wire       shunt_fault_r,
  output wire       shunt_shutdown_r
);

  localparam CW  = 20;
  localparam DW  = `GDPS_DW;
  localparam [DW-1:0] RST_OCP = `GDPS_RST_OCP;
  localparam [DW-1:0] RST_AMP = `GDPS_RST_AMP;
  localparam SEL_NONE = 2'h0;
  localparam SEL_OCP  = 2'h1;
  localparam SEL_AMP  = 2'h2;
  localparam SEL_DRV  = 2'h3;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function [1:0] reg_sel;
    input [3:0] addr;
    begin
      case (addr)
        `GDPS_ADDR_OCP: reg_sel = SEL_OCP;
        `GDPS_ADDR_AMP: reg_sel = SEL_AMP;
        `GDPS_ADDR_DRV: reg_sel = SEL_DRV;
        default:        reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  function [9:0] filt_cyc;
    input [1:0] code;
    integer cyc;
    begin
      case (code)
        2'h0:    cyc = `GDPS_FILT_US_0 * `GDPS_CLK_MHZ;
        2'h1:    cyc = `GDPS_FILT_US_1 * `GDPS_CLK_MHZ;
        2'h2:    cyc = `GDPS_FILT_US_2 * `GDPS_CLK_MHZ;
        default: cyc = `GDPS_FILT_US_3 * `GDPS_CLK_MHZ;
      endcase
      filt_cyc = cyc[9:0];
    end
  endfunction

  function [5:0] gap_cyc;
    input [1:0] code;
    integer cyc;
    begin
      case (code)
        2'h0:    cyc = `GDPS_GAP_NS_0 * `GDPS_CLK_MHZ / 1000;
        2'h1:    cyc = `GDPS_GAP_NS_1 * `GDPS_CLK_MHZ / 1000;
        2'h2:    cyc = `GDPS_GAP_NS_2 * `GDPS_CLK_MHZ / 1000;
        default: cyc = `GDPS_GAP_NS_3 * `GDPS_CLK_MHZ / 1000;
      endcase
      gap_cyc = cyc[5:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg  [4:0] sync1_r;
  reg  [4:0] sync2_r;
  reg        sclk_d_r;
  wire       cs_act;
  wire       sclk_s;
  wire       mosi_s;
  wire       ds_oc_s;
  wire       sh_oc_s;
  wire       sclk_rise;
  wire       sclk_fall;

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync1_r  <= 5'h01;
      sync2_r  <= 5'h01;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      sync1_r  <= {shunt_overcurrent, drain_source_overcurrent,
                   spi_mosi, spi_sclk, spi_cs_n};
      sync2_r  <= sync1_r;
      sclk_d_r <= sync2_r[1];
    end
  end

  assign cs_act    = ~sync2_r[0];
  assign sclk_s    = sync2_r[1];
  assign mosi_s    = sync2_r[2];
  assign ds_oc_s   = sync2_r[3];
  assign sh_oc_s   = sync2_r[4];
  assign sclk_rise = cs_act & sclk_s & ~sclk_d_r;
  assign sclk_fall = cs_act & ~sclk_s & sclk_d_r;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [DW-1:0] ocp_r;
  reg  [DW-1:0] amp_r;
  reg           auto_cal_bit_r;
  reg  [15:0]   rx_r;
  reg  [15:0]   tx_r;
  reg  [4:0]    cnt_r;
  reg           cs_d_r;
  wire          frame_end;
  wire          wr_ok;
  wire [1:0]    wr_sel;
  wire [1:0]    rd_sel;
  wire [14:0]   rx_nxt;
  reg  [DW-1:0] rd_data;

  assign frame_end = cs_d_r & ~cs_act;
  assign wr_ok     = frame_end & (cnt_r == `GDPS_FRAME_BITS)
                     & ~rx_r[`GDPS_RW_BIT];
  assign wr_sel    = reg_sel(rx_r[`GDPS_ADDR_HI:`GDPS_ADDR_LO]);
  assign rx_nxt    = {rx_r[13:0], mosi_s};
  assign rd_sel    = reg_sel(rx_nxt[3:0]);

  // reserved driver bits are not stored and read as zero
  always @*
  begin
    case (rd_sel)
      SEL_OCP: rd_data = ocp_r;
      SEL_AMP: rd_data = amp_r;
      SEL_DRV: rd_data = {{(DW-1){1'b0}}, auto_cal_bit_r};
      default: rd_data = {DW{1'b0}};
    endcase
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      ocp_r          <= `GDPS_RST_OCP;
      amp_r          <= `GDPS_RST_AMP;
      auto_cal_bit_r <= 1'b0;
    end
    else if (wr_ok)
    begin
      case (wr_sel)
        SEL_OCP: ocp_r <= rx_r[DW-1:0];
        SEL_AMP:
        begin
          amp_r <= rx_r[DW-1:0];
          if (rx_r[`GDPS_F_SRC])
            amp_r[`GDPS_F_LSREF] <= 1'b1;
        end
        SEL_DRV: auto_cal_bit_r <= rx_r[`GDPS_F_AUTOCAL];
        default: auto_cal_bit_r <= auto_cal_bit_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial frame engine
  // ----------------------------------------------------------------
  // the reply to a read leaves in the same frame, so the master must
  // give the five header bits time to arrive before data bits go out
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      rx_r          <= 16'h0000;
      tx_r          <= 16'h0000;
      cnt_r         <= 5'h00;
      cs_d_r        <= 1'b0;
      spi_miso_r    <= 1'b0;
      spi_miso_oe_r <= 1'b0;
    end
    else
    begin
      cs_d_r        <= cs_act;
      spi_miso_oe_r <= cs_act;
      if (cs_act && !cs_d_r)
      begin
        cnt_r      <= 5'h00;
        tx_r       <= 16'h0000;
        spi_miso_r <= 1'b0;
      end
      else
      begin
        if (sclk_rise)
        begin
          spi_miso_r <= tx_r[15];
          tx_r       <= {tx_r[14:0], 1'b0};
        end
        if (sclk_fall)
        begin
          rx_r <= {rx_r[14:0], mosi_s};
          if (cnt_r != 5'h1f)
            cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `GDPS_HDR_BITS - 5'h01)
            tx_r <= {rd_data, 5'h00};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      dead_time_cycles_r      <= gap_cyc(RST_OCP[`GDPS_F_GAP]);
      drain_source_trip_sel_r <= RST_OCP[`GDPS_F_DS_LVL];
      amp_input_source_sel_r  <= RST_AMP[`GDPS_F_SRC];
      amp_ref_half_r          <= RST_AMP[`GDPS_F_HALF];
      low_side_trip_ref_sel_r <= RST_AMP[`GDPS_F_LSREF];
      amp_gain_sel_r          <= RST_AMP[`GDPS_F_GAIN];
      shunt_trip_level_sel_r  <= RST_AMP[`GDPS_F_SLVL];
      amp_a_offset_short_r    <= RST_AMP[`GDPS_F_CAL_A];
      amp_b_offset_short_r    <= RST_AMP[`GDPS_F_CAL_B];
      amp_c_offset_short_r    <= RST_AMP[`GDPS_F_CAL_C];
      auto_cal_r              <= 1'b0;
    end
    else
    begin
      dead_time_cycles_r      <= gap_cyc(ocp_r[`GDPS_F_GAP]);
      drain_source_trip_sel_r <= ocp_r[`GDPS_F_DS_LVL];
      amp_input_source_sel_r  <= amp_r[`GDPS_F_SRC];
      amp_ref_half_r          <= amp_r[`GDPS_F_HALF];
      low_side_trip_ref_sel_r <= amp_r[`GDPS_F_LSREF];
      amp_gain_sel_r          <= amp_r[`GDPS_F_GAIN];
      shunt_trip_level_sel_r  <= amp_r[`GDPS_F_SLVL];
      amp_a_offset_short_r    <= amp_r[`GDPS_F_CAL_A];
      amp_b_offset_short_r    <= amp_r[`GDPS_F_CAL_B];
      amp_c_offset_short_r    <= amp_r[`GDPS_F_CAL_C];
      auto_cal_r              <= auto_cal_bit_r;
    end
  end

  // ----------------------------------------------------------------
  // overcurrent responses
  // ----------------------------------------------------------------
  wire [CW-1:0] retry_cyc;
  wire [9:0]    filt;
  wire [1:0]    mode;
  wire          cbc_ok;

  assign retry_cyc = ocp_r[`GDPS_F_RETRY] ? RETRY_SHORT_CYC[CW-1:0]
                                          : RETRY_LONG_CYC[CW-1:0];
  assign filt   = filt_cyc(ocp_r[`GDPS_F_FILT]);
  assign mode   = ocp_r[`GDPS_F_MODE];
  assign cbc_ok = cycle_clear_sel & (mode == `GDPS_MODE_RETRY);

  gdps_oc_guard #(
    .CW (CW)
  ) u_ds_guard (
    .clock        (clock),
    .rst_n        (rst_n),
    .oc_in        (ds_oc_s),
    .enable       (1'b1),
    .mode         (mode),
    .filt_cycles  (filt),
    .retry_cycles (retry_cyc),
    .cycle_clear  (cbc_ok),
    .pwm_edge     (pwm_edge),
    .fault_clear  (fault_clear),
    .report_r     (ds_fault_r),
    .shutdown_r   (ds_shutdown_r)
  );

  gdps_oc_guard #(
    .CW (CW)
  ) u_sh_guard (
    .clock        (clock),
    .rst_n        (rst_n),
    .oc_in        (sh_oc_s),
    .enable       (~amp_r[`GDPS_F_SDIS]),
    .mode         (mode),
    .filt_cycles  (filt),
    .retry_cycles (retry_cyc),
    .cycle_clear  (cbc_ok),
    .pwm_edge     (pwm_edge),
    .fault_clear  (fault_clear),
    .report_r     (shunt_fault_r),
    .shutdown_r   (shunt_shutdown_r)
  );

endmodule

// *** gdps_cfg_chk.sv ***
// gdps_cfg_chk.sv: port-level assertions for the configuration bank.
// assumes: bound to gdps_cfg; one clock, synchronous active-low reset.
`timescale 1ns/100ps

module gdps_cfg_chk #(
  parameter RETRY_LONG_CYC  = 800000,
  parameter RETRY_SHORT_CYC = 5000
) (
  input wire       clock,
  input wire       rst_n,
  input wire       spi_cs_n,
  input wire       drain_source_overcurrent,
  input wire       shunt_overcurrent,
  input wire [5:0] dead_time_cycles_r,
  input wire [3:0] drain_source_trip_sel_r,
  input wire       amp_input_source_sel_r,
  input wire       amp_ref_half_r,
  input wire       low_side_trip_ref_sel_r,
  input wire [1:0] amp_gain_sel_r,
  input wire [1:0] shunt_trip_level_sel_r,
  input wire       auto_cal_r,
  input wire       ds_fault_r,
  input wire       ds_shutdown_r,
  input wire       shunt_fault_r,
  input wire       shunt_shutdown_r
);
  reg [9:0] ds_run_r;
  reg [9:0] sh_run_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------
  // comparator run lengths, saturating
  // ------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_n || !drain_source_overcurrent)
      ds_run_r <= 10'h000;
    else if (ds_run_r != 10'h3ff)
      ds_run_r <= ds_run_r + 10'h001;
    if (!rst_n || !shunt_overcurrent)
      sh_run_r <= 10'h000;
    else if (sh_run_r != 10'h3ff)
      sh_run_r <= sh_run_r + 10'h001;
  end

  reset_dflt_a: assert property (
    $rose(rst_n) |-> dead_time_cycles_r == 6'h0a && !auto_cal_r &&
    drain_source_trip_sel_r == 4'h9 && amp_ref_half_r &&
    amp_gain_sel_r == 2'h2 && shunt_trip_level_sel_r == 2'h3 &&
    !amp_input_source_sel_r && !ds_fault_r && !shunt_fault_r)
    else $error("config outputs not at defaults after reset");
  dead_code_a: assert property (
    dead_time_cycles_r inside {6'h05, 6'h0a, 6'h14, 6'h28})
    else $error("dead time not one of the four settings");
  src_ref_a: assert property (
    amp_input_source_sel_r |-> low_side_trip_ref_sel_r)
    else $error("switch node source without forced trip reference");
  ds_filter_a: assert property (
    $rose(ds_fault_r) |-> $past(ds_run_r, 4) >= 10'h05a)
    else $error("drain-source fault before filter time");
  sh_filter_a: assert property (
    $rose(shunt_fault_r) |-> $past(sh_run_r, 4) >= 10'h05a)
    else $error("shunt fault before filter time");
  ds_shut_a: assert property (
    ds_shutdown_r |-> ds_fault_r)
    else $error("drain-source shutdown without report");
  sh_shut_a: assert property (
    shunt_shutdown_r |-> shunt_fault_r)
    else $error("shunt shutdown without report");
  cfg_hold_a: assert property (
    !spi_cs_n [*6] |=> $stable({dead_time_cycles_r, amp_gain_sel_r,
      drain_source_trip_sel_r, amp_ref_half_r, shunt_trip_level_sel_r,
      amp_input_source_sel_r, low_side_trip_ref_sel_r, auto_cal_r}))
    else $error("configuration changed inside a frame");

  cover property ($rose(ds_shutdown_r));
  cover property ($rose(shunt_fault_r));
  cover property ($rose(auto_cal_r));
endmodule

bind gdps_cfg gdps_cfg_chk #(
  .RETRY_LONG_CYC  (RETRY_LONG_CYC),
  .RETRY_SHORT_CYC (RETRY_SHORT_CYC)
) chk (
  .clock (clock), .rst_n (rst_n), .spi_cs_n (spi_cs_n),
  .drain_source_overcurrent (drain_source_overcurrent),
  .shunt_overcurrent (shunt_overcurrent),
  .dead_time_cycles_r (dead_time_cycles_r),
  .drain_source_trip_sel_r (drain_source_trip_sel_r),
  .amp_input_source_sel_r (amp_input_source_sel_r),
  .amp_ref_half_r (amp_ref_half_r),
  .low_side_trip_ref_sel_r (low_side_trip_ref_sel_r),
  .amp_gain_sel_r (amp_gain_sel_r),
  .shunt_trip_level_sel_r (shunt_trip_level_sel_r),
  .auto_cal_r (auto_cal_r), .ds_fault_r (ds_fault_r),
  .ds_shutdown_r (ds_shutdown_r), .shunt_fault_r (shunt_fault_r),
  .shunt_shutdown_r (shunt_shutdown_r)
);

// *** gdps_ctl_model.sv ***
// gdps_ctl_model.sv: serial register master in the controller's place.
// assumes: tb makes the clock and resolves the pulled-up data-out line.
`timescale 1ns/100ps

module gdps_ctl_model (
  input  wire clock,
  input  wire miso,
  output reg  cs_n,
  output reg  sclk,
  output reg  mosi
);
  integer i;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // half period of 6 clocks stays clear of the 4-clock minimum
  task xfer(input [15:0] w, input integer nb, output [15:0] rd);
  begin
    rd = 16'h0000;
    cs_n <= 1'b0;
    repeat (6) @(posedge clock);
    for (i = nb - 1; i >= 0; i = i - 1)
    begin
      mosi <= w[i];
      sclk <= 1'b1;
      repeat (6) @(posedge clock);
      rd = {rd[14:0], miso};
      sclk <= 1'b0;
      repeat (6) @(posedge clock);
    end
    cs_n <= 1'b1;
    // idle data line flips to the inverse of the last bit sent
    mosi <= ~mosi;
    repeat (12) @(posedge clock);
  end
  endtask
endmodule

// *** gdps_tb.sv ***
// gdps_tb.sv: self-checking bench for the configuration bank.
// assumes: gdps_cfg and the controller model are compiled before it.
`timescale 1ns/100ps

module tb;
  reg         clock;
  reg         rst_n;
  reg         ds_oc;
  reg         sh_oc;
  reg         pwm_edge;
  reg         fault_clear;
  reg         cc_sel;
  wire        cs_n;
  wire        sclk;
  wire        mosi;
  wire        miso_r;
  wire        miso_oe;
  wire        miso;
  wire [5:0]  dead;
  wire [3:0]  ds_trip;
  wire        src;
  wire        half;
  wire        lsref;
  wire [1:0]  gain;
  wire [1:0]  slvl;
  wire [3:0]  cal;
  wire [3:0]  flt;
  wire [24:0] cfg;
  integer     mismatches;
  integer     check_count;
  integer     k;
  reg [15:0]  r;

  // tri-state data out with pull-up
  assign miso = miso_oe ? miso_r : 1'b1;
  assign cfg = {dead, ds_trip, src, half, lsref, gain, slvl, cal, flt};

  gdps_cfg #(.RETRY_LONG_CYC(200), .RETRY_SHORT_CYC(50)) uut (
    .clock (clock), .rst_n (rst_n), .spi_cs_n (cs_n),
    .spi_sclk (sclk), .spi_mosi (mosi), .spi_miso_r (miso_r),
    .spi_miso_oe_r (miso_oe), .drain_source_overcurrent (ds_oc),
    .shunt_overcurrent (sh_oc), .pwm_edge (pwm_edge),
    .fault_clear (fault_clear), .cycle_clear_sel (cc_sel),
    .dead_time_cycles_r (dead), .drain_source_trip_sel_r (ds_trip),
    .amp_input_source_sel_r (src), .amp_ref_half_r (half),
    .low_side_trip_ref_sel_r (lsref), .amp_gain_sel_r (gain),
    .shunt_trip_level_sel_r (slvl), .amp_a_offset_short_r (cal[3]),
    .amp_b_offset_short_r (cal[2]), .amp_c_offset_short_r (cal[1]),
    .auto_cal_r (cal[0]), .ds_fault_r (flt[3]),
    .ds_shutdown_r (flt[2]), .shunt_fault_r (flt[1]),
    .shunt_shutdown_r (flt[0])
  );

  gdps_ctl_model ctl (
    .clock (clock), .miso (miso), .cs_n (cs_n), .sclk (sclk),
    .mosi (mosi)
  );

  // ------------------------------------------
  // access and compare tasks
  // ------------------------------------------
  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
    end
  end
  endtask

  task wr(input [3:0] a, input [10:0] d);
    ctl.xfer({1'b0, a, d}, 16, r);
  endtask

  task rd(input [3:0] a, input [10:0] exp);
  begin
    ctl.xfer({1'b1, a, 11'h000}, 16, r);
    chk(32'(r), 32'(exp));
  end
  endtask

  // hold one comparator high, drop it, then look at its fault pair
  task trip(input s, input integer hold, input integer after,
            input [1:0] e);
  begin
    if (s)
      sh_oc <= 1'b1;
    else
      ds_oc <= 1'b1;
    tick(hold);
    sh_oc <= 1'b0;
    ds_oc <= 1'b0;
    tick(after);
    chk(32'(s ? flt[1:0] : flt[3:2]), 32'(e));
  end
  endtask

  task pulse(input clr);
  begin
    fault_clear <= clr;
    pwm_edge <= !clr;
    tick(1);
    fault_clear <= 1'b0;
    pwm_edge <= 1'b0;
    tick(3);
  end
  endtask

  task complete_run;
  begin
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    tick(30000);
    mismatches = mismatches + 1;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    complete_run;
  end

  // ------------------------------------------
  // test sequence
  // ------------------------------------------
  initial
  begin
    mismatches = 0;
    check_count = 0;
    rst_n = 1'b0;
    ds_oc = 1'b0;
    sh_oc = 1'b0;
    pwm_edge = 1'b0;
    fault_clear = 1'b0;
    cc_sel = 1'b0;
    tick(16);
    rst_n <= 1'b1;
    tick(2);
    chk(32'(cfg), 32'({6'h0a, 4'h9, 3'b010, 2'h2, 2'h3, 8'h00}));
    rd(4'h5, 11'h169);
    rd(4'h6, 11'h283);
    rd(4'h7, 11'h000);
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(4'h5, {1'b0, k[1:0], 8'h69});
      chk(32'(dead), 32'h5 << k);
      rd(4'h5, {1'b0, k[1:0], 8'h69});
      wr(4'h6, {3'b010, k[1:0], 4'h0, k[1:0]});
      chk(32'({gain, slvl}), 32'({k[1:0], k[1:0]}));
    end
    wr(4'h6, 11'h41c);
    rd(4'h6, 11'h51c);
    chk(32'(cfg[14:5]), 32'h287);
    wr(4'h6, 11'h100);
    chk(32'(cfg[14:5]), 32'h080);
    wr(4'h6, 11'h200);
    chk(32'(cfg[14:5]), 32'h100);
    wr(4'h7, 11'h7ff);
    rd(4'h7, 11'h001);
    chk(32'(cal[0]), 32'h1);
    wr(4'h7, 11'h7fe);
    chk(32'(cal[0]), 32'h0);
    // unmapped place and a short frame must leave everything alone
    wr(4'h8, 11'h7ff);
    rd(4'h8, 11'h000);
    ctl.xfer(16'h0b55, 12, r);
    rd(4'h6, 11'h200);
    for (k = 0; k < 4; k = k + 1)
    begin
      wr(4'h5, {3'b101, 2'b10, k[1:0], 4'h9});
      ds_oc <= 1'b1;
      tick((100 << k) - 10);
      chk(32'(flt[3]), 32'h0);
      trip(1'b0, 40, 0, 2'b10);
      tick(10);
      chk(32'(flt[3]), 32'h0);
    end
    wr(4'h5, {3'b101, 2'b11, 2'b00, 4'h9});
    trip(1'b0, 130, 0, 2'b00);
    wr(4'h5, {3'b101, 2'b00, 2'b00, 4'h9});
    cc_sel <= 1'b1;
    trip(1'b0, 130, 300, 2'b11);
    pulse(1'b0);
    chk(32'(flt[3:2]), 32'h3);
    pulse(1'b1);
    chk(32'(flt[3:2]), 32'h0);
    wr(4'h5, {3'b101, 2'b01, 2'b00, 4'h9});
    trip(1'b0, 130, 0, 2'b11);
    tick(60);
    chk(32'(flt[3:2]), 32'h0);
    wr(4'h5, {3'b001, 2'b01, 2'b00, 4'h9});
    trip(1'b0, 130, 100, 2'b11);
    tick(100);
    chk(32'(flt[3:2]), 32'h0);
    trip(1'b0, 130, 5, 2'b11);
    pulse(1'b0);
    chk(32'(flt[3:2]), 32'h0);
    wr(4'h5, {3'b101, 2'b01, 2'b00, 4'h9});
    wr(4'h6, 11'h2a3);
    trip(1'b1, 130, 0, 2'b00);
    wr(4'h6, 11'h283);
    trip(1'b1, 130, 0, 2'b11);
    tick(80);
    rst_n <= 1'b0;
    tick(16);
    rst_n <= 1'b1;
    tick(2);
    rd(4'h5, 11'h169);
    complete_run;
  end
endmodule
